// *** logic/odrc_defs.svh ***
`ifndef ODRC_DEFS_SVH
`define ODRC_DEFS_SVH

// Register offsets
`define ODRC_OFS_ID 8'h0D
`define ODRC_OFS_RANGE 8'h0E
`define ODRC_OFS_STATUS 8'h10
`define ODRC_OFS_CFG 8'h11
`define ODRC_OFS_DBNC 8'h12
`define ODRC_OFS_IRQ_SRC 8'h0C
`define ODRC_OFS_IRQ_MASK 8'h0F

// Field positions
`define ODRC_BIT_CHANGED 7
`define ODRC_BIT_LOCKOUT 6
`define ODRC_BIT_BACK 0
`define ODRC_BIT_DBMODE 7
`define ODRC_BIT_ENABLE 6
`define ODRC_BIT_IRQ_ORIENT 4

// Reset values
`define ODRC_RST_RANGE 2'h0
`define ODRC_RST_DBMODE 1'h1
`define ODRC_RST_ENABLE 1'h0
`define ODRC_RST_DBNC 8'h00
`define ODRC_ID_VALUE 8'hA7 // Arbitrary part code of our own choosing

// Range codes
`define ODRC_RANGE_2G 2'h0
`define ODRC_RANGE_4G 2'h1
`define ODRC_RANGE_8G 2'h2

`endif

// *** logic/odrc_pkg.sv ***
package odrc_pkg;
	// Orientation result carried between the classifier and this block
	typedef struct packed {
		logic lockout;
		logic [1:0] pl_code;
		logic back;
	} odrc_orient_s;

	// Sequencer states
	typedef enum logic [2:0] {
		ODRC_IDLE = 3'h1,
		ODRC_FIRST = 3'h2,
		ODRC_RUN = 3'h4
	} odrc_state_e;

	// All state of the block
	typedef struct packed {
		odrc_state_e state;
		logic [1:0] range;
		logic dbmode;
		logic enable;
		logic [7:0] dbnc;
		odrc_orient_s shown;
		odrc_orient_s cand;
		logic [7:0] cnt;
		logic changed;
		logic irq_src;
		logic irq_mask;
		logic wake_seen;
		logic [7:0] rdata;
	} odrc_state_s;
endpackage

// *** logic/odrc_top.sv ***
`timescale 1ns/1ps
`include "odrc_defs.svh"
// What this block does
// - Read-only identity register at 0x0D; writes ignored.
// - Two-bit range field: 00 2g default, 01 4g, 10 8g, 11 reserved.
// - Changed flag bit 7 sets on first result after enable, and on any change.
// - Reading orientation status clears changed flag and its interrupt.
// - Lockout bit 6 is one while the tilt lockout angle is exceeded.
// - Code bits 2:1: 00 up, 01 down, 10 right, 11 left.
// - Bit 0 is zero facing front, one facing back.
// - After reset back, code and lockout are all zero.
// - Orientation held while any axis exceeds 1.25 g.
// - Outputs keep updating while changed flag stays set.
// - Debounce mode bit 7: zero decrements, one clears the counter; reset one.
// - Enable bit 6 turns detection on; reset off.
// - Eight-bit debounce count register, reset zero, sets persistence in steps.
// - Least latency equals count times the sample step.
// - Each wake/sleep transition resets the debounce counter.
// - One step per sample tick; step length set by rate and mode outside.
// - Interrupt source bit 4 sets with the changed flag whatever the mask bit; the mask only gates irq_out; status read clears it.
module odrc_top (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Sample path
	input wire logic sample_tick_in,
	input wire odrc_pkg::odrc_orient_s raw_orient_in,
	input wire logic over_limit_in,
	input wire logic sleep_mode_in,
	// Results
	output logic [1:0] range_out,
	output odrc_pkg::odrc_orient_s orient_out,
	output logic irq_out
);

	odrc_pkg::odrc_state_s st_reg;
	odrc_pkg::odrc_state_s st_next;

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	// Shared by the read mux and read side effects
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
		is_reg = (a == ofs);
	endfunction

	logic [7:0] status_view;
	logic [7:0] read_value;
	logic status_read;
	logic changed_event;
	logic invalid;

	// Status byte layout
	always_comb begin
		status_view = 8'h00;
		status_view[`ODRC_BIT_CHANGED] = st_reg.changed;
		status_view[`ODRC_BIT_LOCKOUT] = st_reg.shown.lockout;
		status_view[2:1] = st_reg.shown.pl_code;
		status_view[`ODRC_BIT_BACK] = st_reg.shown.back;
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		read_value = 8'h00;
		if (is_reg(addr_in, `ODRC_OFS_ID)) begin
			read_value = `ODRC_ID_VALUE;
		end else if (is_reg(addr_in, `ODRC_OFS_RANGE)) begin
			read_value = {6'h00, st_reg.range};
		end else if (is_reg(addr_in, `ODRC_OFS_STATUS)) begin
			read_value = status_view;
		end else if (is_reg(addr_in, `ODRC_OFS_CFG)) begin
			read_value = {st_reg.dbmode, st_reg.enable, 6'h00};
		end else if (is_reg(addr_in, `ODRC_OFS_DBNC)) begin
			read_value = st_reg.dbnc;
		end else if (is_reg(addr_in, `ODRC_OFS_IRQ_SRC)) begin
			read_value = {3'h0, st_reg.irq_src, 4'h0};
		end else if (is_reg(addr_in, `ODRC_OFS_IRQ_MASK)) begin
			read_value = {3'h0, st_reg.irq_mask, 4'h0};
		end
	end

	assign status_read = rd_in && is_reg(addr_in, `ODRC_OFS_STATUS);
	// Nothing pending while raw matches what is shown; over-range samples never count
	assign invalid = (raw_orient_in == st_reg.shown) || over_limit_in;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		changed_event = 1'b0;
		if (ce_in) begin
			st_next.rdata = rd_in ? read_value : st_reg.rdata;
			// Register writes; identity and status are read-only
			if (wr_in) begin
				if (is_reg(addr_in, `ODRC_OFS_RANGE)) begin
					st_next.range = wdata_in[1:0];
				end
				if (is_reg(addr_in, `ODRC_OFS_CFG)) begin
					st_next.dbmode = wdata_in[`ODRC_BIT_DBMODE];
					st_next.enable = wdata_in[`ODRC_BIT_ENABLE];
				end
				if (is_reg(addr_in, `ODRC_OFS_DBNC)) begin
					st_next.dbnc = wdata_in;
				end
				if (is_reg(addr_in, `ODRC_OFS_IRQ_MASK)) begin
					st_next.irq_mask = wdata_in[`ODRC_BIT_IRQ_ORIENT];
				end
			end
			// Detection sequencer
			case (st_reg.state)
				odrc_pkg::ODRC_IDLE: begin
					st_next.cnt = 8'h00;
					if (st_reg.enable) begin
						st_next.state = odrc_pkg::ODRC_FIRST;
					end
				end
				odrc_pkg::ODRC_FIRST: begin
					// First result after activation always flags, even if unchanged
					if (!st_reg.enable) begin
						st_next.state = odrc_pkg::ODRC_IDLE;
					end else if (sample_tick_in && !over_limit_in) begin
						st_next.shown = raw_orient_in;
						changed_event = 1'b1;
						st_next.state = odrc_pkg::ODRC_RUN;
					end
				end
				odrc_pkg::ODRC_RUN: begin
					if (!st_reg.enable) begin
						st_next.state = odrc_pkg::ODRC_IDLE;
					end else if (sample_tick_in) begin
						// One step per sample, so latency is count times step
						if (invalid || (raw_orient_in != st_reg.cand && st_reg.cnt != 8'h00)) begin
							st_next.cand = raw_orient_in;
							if (st_reg.dbmode || st_reg.cnt == 8'h00) begin
								st_next.cnt = 8'h00;
							end else begin
								st_next.cnt = st_reg.cnt - 8'h01;
							end
						end else if (st_reg.cnt >= st_reg.dbnc) begin
							// Updates continue regardless of the changed flag
							st_next.shown = raw_orient_in;
							st_next.cnt = 8'h00;
							changed_event = 1'b1;
						end else begin
							st_next.cand = raw_orient_in;
							st_next.cnt = st_reg.cnt + 8'h01;
						end
					end
				end
				default: begin
					st_next.state = odrc_pkg::ODRC_IDLE;
				end
			endcase
			// Mode changes restart debouncing
			st_next.wake_seen = sleep_mode_in;
			if (sleep_mode_in != st_reg.wake_seen) begin
				st_next.cnt = 8'h00;
			end
			// Set wins over the clear by read
			if (changed_event) begin
				st_next.changed = 1'b1;
				st_next.irq_src = 1'b1;
			end else if (status_read) begin
				st_next.changed = 1'b0;
				st_next.irq_src = 1'b0;
			end
			// Write one also clears the sticky source
			if (!changed_event && wr_in && is_reg(addr_in, `ODRC_OFS_IRQ_SRC)
				&& wdata_in[`ODRC_BIT_IRQ_ORIENT]) begin
				st_next.irq_src = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_reg <= '0;
			st_reg.state <= odrc_pkg::ODRC_IDLE;
			st_reg.range <= `ODRC_RST_RANGE;
			st_reg.dbmode <= `ODRC_RST_DBMODE;
			st_reg.enable <= `ODRC_RST_ENABLE;
			st_reg.dbnc <= `ODRC_RST_DBNC;
			st_reg.shown <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign rdata_out = st_reg.rdata;
	assign range_out = st_reg.range;
	assign orient_out = st_reg.shown;
	assign irq_out = st_reg.irq_src & st_reg.irq_mask;

endmodule

// *** tb/odrc_host.sv ***
`timescale 1ns/1ps
// ----
// Host model
// ----
module odrc_host (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
	// One-cycle strobe; released lines flip so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_out <= w;
		rd_out <= !w;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
endmodule

// *** tb/odrc_props.sv ***
`timescale 1ns/1ps
// ----
// Port checks
// ----
module odrc_props (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Inputs
	input wire logic ce_in,
	input wire logic [7:0] addr_in,
	input wire logic rd_in,
	input wire logic sample_tick_in,
	input wire logic over_limit_in,
	// Outputs
	input wire logic [7:0] rdata_out,
	input wire logic [1:0] range_out,
	input wire odrc_pkg::odrc_orient_s orient_out,
	input wire logic irq_out
);
	// Read address, or a dead value when no read strobe is up
	logic [7:0] ra;
	assign ra = rd_in ? addr_in : 8'hFF;
	default clocking @(posedge clk_in); endclocking
	// A frozen clock enable cancels any check in flight
	default disable iff (!nrst_in || !ce_in);
	a_ident_fixed: assert property (ra == 8'h0D |=> rdata_out == 8'hA7)
		else $error("identity read wrong");
	a_range_read: assert property (ra == 8'h0E |=> rdata_out == {6'h00, $past(range_out)})
		else $error("range read wrong");
	a_status_bits: assert property (ra == 8'h10 && !sample_tick_in |=> rdata_out[6:0] == {orient_out.lockout, 3'h0, orient_out.pl_code, orient_out.back})
		else $error("status bits wrong");
	a_read_clears: assert property (ra == 8'h10 && !sample_tick_in ##1 !sample_tick_in |=> !irq_out)
		else $error("irq not cleared");
	a_hold_limit: assert property (sample_tick_in && over_limit_in |=> $stable(orient_out))
		else $error("moved over limit");
	a_move_on_tick: assert property (!sample_tick_in |=> $stable(orient_out))
		else $error("moved off tick");
	a_cfg_unused: assert property (ra == 8'h11 |=> rdata_out[5:0] == 6'h00)
		else $error("config unused bits set");
	a_unmapped_zero: assert property (ra == 8'h00 |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	cover property (irq_out);
	cover property (sample_tick_in && over_limit_in);
	cover property (ra == 8'h10 && irq_out);
endmodule
bind odrc_top odrc_props odrc_props_i (.*);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic ce = 1'b1;
	logic tick = 1'b0;
	logic ovl = 1'b0;
	logic slp = 1'b0;
	logic rd_d = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, irq;
	logic [1:0] rng;
	odrc_pkg::odrc_orient_s raw = '0;
	odrc_pkg::odrc_orient_s shown, o0, o1, o2;
	logic [7:0] expq[$];
	int n_errors = 0;
	int check_count = 0;
	initial forever #20 clk_in = ~clk_in;
	odrc_host odrc_host_i (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	odrc_top odrc_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sample_tick_in(tick), .raw_orient_in(raw),
		.over_limit_in(ovl), .sleep_mode_in(slp), .range_out(rng), .orient_out(shown), .irq_out(irq));
	// ----
	// Tasks
	// ----
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		odrc_host_i.xfer(1'b0, a, 8'h00);
	endtask
	// Classifier result stays as a level after the tick
	task automatic tk(input odrc_pkg::odrc_orient_s r, input logic l, input int n);
		repeat (n) begin
			@(posedge clk_in);
			tick <= 1'b1;
			raw <= r;
			ovl <= l;
			@(posedge clk_in);
			tick <= 1'b0;
		end
	endtask
	function automatic logic [7:0] st(input logic c, input odrc_pkg::odrc_orient_s o);
		return {c, o.lockout, 3'h0, o.pl_code, o.back};
	endfunction
	task automatic close_out();
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Read data is checked in the cycle after the strobe; it holds until the next read
	always @(posedge clk_in) begin
		rd_d <= rd;
		if (rd_d) chk("rdata", expq.pop_front(), rdata);
	end
	// Whole run is under two hundred cycles
	initial begin
		#(40 * 5000);
		n_errors++;
		close_out();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		void'($urandom(18));
		o0 = 4'($urandom);
		o1 = o0 ^ 4'h5;
		o2 = o1 ^ 4'hA;
		repeat (10) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd_exp(8'h0D, 8'hA7);
		odrc_host_i.xfer(1'b1, 8'h0D, 8'h00);
		rd_exp(8'h0D, 8'hA7);
		rd_exp(8'h10, 8'h00);
		rd_exp(8'h11, 8'h80);
		rd_exp(8'h12, 8'h00);
		rd_exp(8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			odrc_host_i.xfer(1'b1, 8'h0E, 8'hFC | 8'(i));
			#1 chk("range", 8'(i), {6'h00, rng});
			rd_exp(8'h0E, 8'(i));
		end
		odrc_host_i.xfer(1'b1, 8'h0F, 8'h10);
		odrc_host_i.xfer(1'b1, 8'h12, 8'h02);
		odrc_host_i.xfer(1'b1, 8'h11, 8'h40);
		tk(o0, 1'b0, 1);
		@(posedge clk_in);
		#1 chk("irq", 8'h01, {7'h00, irq});
		rd_exp(8'h10, st(1'b1, o0));
		rd_exp(8'h10, st(1'b0, o0));
		#1 chk("irq", 8'h00, {7'h00, irq});
		// A low clock enable must swallow these ticks, or the next read shows a change
		@(posedge clk_in);
		ce <= 1'b0;
		tk(o1, 1'b0, 3);
		ce <= 1'b1;
		tk(o1, 1'b0, 2);
		rd_exp(8'h10, st(1'b0, o0));
		tk(o1, 1'b0, 1);
		rd_exp(8'h10, st(1'b1, o1));
		tk(o2, 1'b1, 4);
		rd_exp(8'h10, st(1'b0, o1));
		tk(o2, 1'b0, 3);
		tk(o0, 1'b0, 3);
		rd_exp(8'h10, st(1'b1, o0));
		tk(o1, 1'b0, 2);
		slp <= 1'b1;
		tk(o1, 1'b0, 2);
		rd_exp(8'h10, st(1'b0, o0));
		#1 chk("orient", {4'h0, o0}, {4'h0, shown});
		// Clearing mode: an over-limit tick drops the count to zero, not by one
		odrc_host_i.xfer(1'b1, 8'h11, 8'hC0);
		tk(o0, 1'b0, 1);
		tk(o1, 1'b0, 2);
		tk(o1, 1'b1, 1);
		tk(o1, 1'b0, 2);
		rd_exp(8'h10, st(1'b0, o0));
		tk(o1, 1'b0, 1);
		rd_exp(8'h10, st(1'b1, o1));
		// Off and on again flags the first result even when unchanged
		odrc_host_i.xfer(1'b1, 8'h11, 8'h80);
		odrc_host_i.xfer(1'b1, 8'h11, 8'hC0);
		tk(o1, 1'b0, 1);
		rd_exp(8'h0C, 8'h10);
		odrc_host_i.xfer(1'b1, 8'h0C, 8'h10);
		rd_exp(8'h0C, 8'h00);
		rd_exp(8'h0F, 8'h10);
		rd_exp(8'h10, st(1'b1, o1));
		// Reset in mid-run returns irq, orientation, status, config and range to their reset values
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		#1 chk("irq", 8'h00, {7'h00, irq});
		chk("orient", 8'h00, {4'h0, shown});
		rd_exp(8'h10, 8'h00);
		rd_exp(8'h11, 8'h80);
		rd_exp(8'h0E, 8'h00);
		repeat (2) @(posedge clk_in);
		close_out();
	end
endmodule
